// *** hw/cam_adv_consts.vh ***
// Function
// - Zero written to trigger bit fires trigger, in trigger mode zero only
// - Trigger field reads ready, transfer, integrating
// - Top bit reads feature presence flag, except in tile map and tile gains
// - Tile map is read only
// - Tile bytes hold ASCII colour initials
// - Tile map pixel order by byte position
// - Tile gains share tile map layout
// - Gain write forces colour balance on
// - Gains reset to 32, range 0-63
// - Layout select: 0 standard, 1 vendor
// - Standard layout: MSB aligned, big-endian
// - Vendor layout: low bits first, reversed
// - Exposure bounds: 8-bit low, 16-bit high
// - Auto exposure clamped between bounds
`ifndef CAM_ADV_CONSTS_VH
`define CAM_ADV_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_SOFT_TRIG     16'h102c
`define OFS_TILE_MAP      16'h1040
`define OFS_TILE_GAINS    16'h1044
`define OFS_LUMA_LAYOUT   16'h1048
`define OFS_AE_BOUNDS     16'h1088

// ----------------------------------------------------------------
// Field positions, bit 0 is the least significant bit
// ----------------------------------------------------------------
`define PRESENCE_BIT      31
`define TRIG_LSB          0
`define TRIG_MSB          1
`define LAYOUT_BIT        0
`define AE_MIN_LSB        16
`define AE_MIN_MSB        23
`define AE_MAX_LSB        0
`define AE_MAX_MSB        15

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define TRIG_ST_BUSY      2'h0
`define TRIG_ST_READY     2'h1
`define TRIG_ST_INTEG     2'h2
`define ASCII_RED         8'h52
`define ASCII_GREEN       8'h47
`define ASCII_BLUE        8'h42
`define ASCII_MONO        8'h59
`define GAIN_RESET        8'h20
`define GAIN_MAX          8'h3f
`define LAYOUT_STANDARD   1'b0
`define LAYOUT_VENDOR     1'b1
`define AE_MIN_RESET      8'h00
`define AE_MAX_RESET      16'hffff
`define AE_VALUE_RESET    16'h0000

`endif

// *** hw/luma16_packer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "cam_adv_consts.vh"

module luma16_packer (
	input  wire       clock,
	input  wire       rst_n,
	input  wire       layout_sel,
	input  wire       pix_valid,
	input  wire [9:0] pix_data,
	output reg        word_valid,
	output reg  [7:0] first_byte,
	output reg  [7:0] second_byte
);

// ----------------------------------------------------------------
// Byte ordering
// ----------------------------------------------------------------
// The don't-care bits are driven as zero so that a capture is repeatable.
always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		word_valid  <= 1'b0;
		first_byte  <= 8'h00;
		second_byte <= 8'h00;
	end else begin
		word_valid <= pix_valid;
		if (pix_valid) begin
			if (layout_sel == `LAYOUT_VENDOR) begin
				first_byte  <= {pix_data[1:0], 6'h00};
				second_byte <= pix_data[9:2];
			end else begin
				first_byte  <= pix_data[9:2];
				second_byte <= {pix_data[1:0], 6'h00};
			end
		end
	end
end

endmodule
`default_nettype wire

// *** hw/cam_adv_regs.v ***
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cam_adv_consts.vh"

module cam_adv_regs #(
	parameter [0:0]  TRIG_PRESENT   = 1'b1,
	parameter [0:0]  MAP_PRESENT    = 1'b1,
	parameter [0:0]  GAIN_PRESENT   = 1'b1,
	parameter [0:0]  LAYOUT_PRESENT = 1'b1,
	parameter [0:0]  AE_PRESENT     = 1'b1,
	parameter [31:0] TILE_MAP_VALUE = {`ASCII_RED, `ASCII_GREEN,
	                                   `ASCII_GREEN, `ASCII_BLUE}
) (
	input  wire        clock,
	input  wire        rstn,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [15:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        trigger_mode_zero,
	input  wire        integrating,
	input  wire        transferring,
	output reg         trigger_pulse,
	output reg         balance_force_on,
	output reg  [31:0] tile_gains,
	output reg         luma_layout,
	input  wire        ae_auto,
	input  wire [15:0] ae_request,
	output reg  [15:0] ae_value,
	input  wire        pix_valid,
	input  wire [9:0]  pix_data,
	output wire        word_valid,
	output wire [7:0]  first_byte,
	output wire [7:0]  second_byte
);

// ----------------------------------------------------------------
// Reset release
// ----------------------------------------------------------------
reg sync1_reg;
reg rst_n_reg;

always @(posedge clock or negedge rstn) begin
	if (!rstn) begin
		sync1_reg <= 1'b0;
		rst_n_reg <= 1'b0;
	end else begin
		sync1_reg <= 1'b1;
		rst_n_reg <= sync1_reg;
	end
end

// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
wire req      = wb_cyc_i & wb_stb_i;
wire hit_trig = (wb_adr_i == `OFS_SOFT_TRIG);
wire hit_map  = (wb_adr_i == `OFS_TILE_MAP);
wire hit_gain = (wb_adr_i == `OFS_TILE_GAINS);
wire hit_lay  = (wb_adr_i == `OFS_LUMA_LAYOUT);
wire hit_ae   = (wb_adr_i == `OFS_AE_BOUNDS);

// A write is committed on the edge at which the master sees ack, so a
// request withdrawn early never alters state.
wire wr_commit = req & wb_we_i & wb_ack_o;

// ----------------------------------------------------------------
// Write strobes
// ----------------------------------------------------------------
// Each strobe is already qualified by its presence flag, so an absent
// feature keeps its reset contents whatever software writes.
wire wr_trig  = wr_commit & hit_trig & TRIG_PRESENT;
wire wr_gain  = wr_commit & hit_gain & GAIN_PRESENT;
wire wr_lay   = wr_commit & hit_lay & LAYOUT_PRESENT;
wire wr_ae    = wr_commit & hit_ae & AE_PRESENT;
wire rd_start = req & ~wb_ack_o & ~wb_we_i;

// ----------------------------------------------------------------
// Trigger status
// ----------------------------------------------------------------
reg [1:0] trig_status;

always @* begin
	if (integrating)
		trig_status = `TRIG_ST_INTEG;
	else if (transferring)
		trig_status = `TRIG_ST_BUSY;
	else
		trig_status = `TRIG_ST_READY;
end

// ----------------------------------------------------------------
// Software trigger
// ----------------------------------------------------------------
reg trig_fire;

always @* begin
	trig_fire = wr_trig & wb_sel_i[0] & trigger_mode_zero & ~wb_dat_i[`TRIG_LSB];
end

// The pulse is not gated by the ready status, so software alone paces the
// triggers and a trigger during integration is passed on as it comes.
always @(posedge clock or negedge rst_n_reg) begin
	if (!rst_n_reg)
		trigger_pulse <= 1'b0;
	else
		trigger_pulse <= trig_fire;
end

// ----------------------------------------------------------------
// Tile gains
// ----------------------------------------------------------------
wire [31:0] gains_next;

// Gain lanes: one byte lane per pixel of the tile.
genvar lane;
generate
	for (lane = 0; lane < 4; lane = lane + 1) begin : gain_lane
		wire [7:0] wr_byte = wb_dat_i[lane*8 +: 8];
		wire       lane_wr = wr_gain & wb_sel_i[lane];
		// Out-of-range writes saturate rather than wrap.
		wire [7:0] wr_clip = (wr_byte > `GAIN_MAX) ? `GAIN_MAX : wr_byte;
		assign gains_next[lane*8 +: 8] = lane_wr ? wr_clip : tile_gains[lane*8 +: 8];
	end
endgenerate

always @(posedge clock or negedge rst_n_reg) begin
	if (!rst_n_reg)
		tile_gains <= {4{`GAIN_RESET}};
	else
		tile_gains <= gains_next;
end

// ----------------------------------------------------------------
// Colour balance force
// ----------------------------------------------------------------
// Any tile gains write forces balance on, whatever its lanes or data, so the pulse
// ignores the byte selects.
reg balance_next;

always @* begin
	balance_next = wr_gain;
end

always @(posedge clock or negedge rst_n_reg) begin
	if (!rst_n_reg)
		balance_force_on <= 1'b0;
	else
		balance_force_on <= balance_next;
end

// ----------------------------------------------------------------
// Luminance layout select
// ----------------------------------------------------------------
reg layout_next;

always @* begin
	layout_next = luma_layout;
	if (wr_lay & wb_sel_i[0])
		layout_next = wb_dat_i[`LAYOUT_BIT];
end

always @(posedge clock or negedge rst_n_reg) begin
	if (!rst_n_reg)
		luma_layout <= `LAYOUT_STANDARD;
	else
		luma_layout <= layout_next;
end

// ----------------------------------------------------------------
// Exposure bounds
// ----------------------------------------------------------------
reg [7:0]  ae_min_reg;
reg [15:0] ae_max_reg;
reg [7:0]  ae_min_next;
reg [15:0] ae_max_next;

always @* begin
	ae_min_next = ae_min_reg;
	ae_max_next = ae_max_reg;
	if (wr_ae) begin
		if (wb_sel_i[2])
			ae_min_next = wb_dat_i[`AE_MIN_MSB:`AE_MIN_LSB];
		if (wb_sel_i[1])
			ae_max_next[15:8] = wb_dat_i[15:8];
		if (wb_sel_i[0])
			ae_max_next[7:0] = wb_dat_i[7:0];
	end
end

always @(posedge clock or negedge rst_n_reg) begin
	if (!rst_n_reg) begin
		ae_min_reg <= `AE_MIN_RESET;
		ae_max_reg <= `AE_MAX_RESET;
	end else begin
		ae_min_reg <= ae_min_next;
		ae_max_reg <= ae_max_next;
	end
end

// ----------------------------------------------------------------
// Exposure clamp
// ----------------------------------------------------------------
// If software programs the lower bound above the upper, the upper wins.
reg [15:0] ae_next;

always @* begin
	ae_next = ae_request;
	if (ae_next < {8'h00, ae_min_reg})
		ae_next = {8'h00, ae_min_reg};
	if (ae_next > ae_max_reg)
		ae_next = ae_max_reg;
end

// ----------------------------------------------------------------
// Exposure output
// ----------------------------------------------------------------
reg [15:0] ae_value_next;

always @* begin
	if (ae_auto & AE_PRESENT)
		ae_value_next = ae_next;
	else
		ae_value_next = ae_request;
end

always @(posedge clock or negedge rst_n_reg) begin
	if (!rst_n_reg)
		ae_value <= `AE_VALUE_RESET;
	else
		ae_value <= ae_value_next;
end

// ----------------------------------------------------------------
// Read words
// ----------------------------------------------------------------
reg [31:0] trig_word;
reg [31:0] map_word;
reg [31:0] gain_word;
reg [31:0] lay_word;
reg [31:0] ae_word;
reg [31:0] rd_next;
reg        ack_next;
reg [31:0] dat_next;

always @* begin
	trig_word = 32'h00000000;
	trig_word[`PRESENCE_BIT] = TRIG_PRESENT;
	if (TRIG_PRESENT)
		trig_word[`TRIG_MSB:`TRIG_LSB] = trig_status;
end

// The map and the gains fill the whole word, so they carry no presence bit
// and an absent feature reads as zero.
always @* begin
	map_word = 32'h00000000;
	if (MAP_PRESENT)
		map_word = TILE_MAP_VALUE;
end

always @* begin
	gain_word = 32'h00000000;
	if (GAIN_PRESENT)
		gain_word = tile_gains;
end

always @* begin
	lay_word = 32'h00000000;
	lay_word[`PRESENCE_BIT] = LAYOUT_PRESENT;
	lay_word[`LAYOUT_BIT]   = luma_layout;
end

always @* begin
	ae_word = 32'h00000000;
	ae_word[`PRESENCE_BIT] = AE_PRESENT;
	ae_word[`AE_MIN_MSB:`AE_MIN_LSB] = ae_min_reg;
	ae_word[`AE_MAX_MSB:`AE_MAX_LSB] = ae_max_reg;
end

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
// Unmapped addresses read as zero and are still acknowledged, so software
// never hangs on a stray access.
always @* begin
	rd_next = 32'h00000000;
	if (hit_trig)
		rd_next = trig_word;
	else if (hit_map)
		rd_next = map_word;
	else if (hit_gain)
		rd_next = gain_word;
	else if (hit_lay)
		rd_next = lay_word;
	else if (hit_ae)
		rd_next = ae_word;
end

// ----------------------------------------------------------------
// Acknowledge
// ----------------------------------------------------------------
always @* begin
	ack_next = req & ~wb_ack_o;
	dat_next = 32'h00000000;
	if (rd_start)
		dat_next = rd_next;
end

// Read data stand only in the acknowledge cycle and are zero otherwise.
always @(posedge clock or negedge rst_n_reg) begin
	if (!rst_n_reg) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h00000000;
	end else begin
		wb_ack_o <= ack_next;
		wb_dat_o <= dat_next;
	end
end

// ----------------------------------------------------------------
// Luminance formatter
// ----------------------------------------------------------------
luma16_packer i_luma16_packer (
	.clock       (clock),
	.rst_n       (rst_n_reg),
	.layout_sel  (luma_layout),
	.pix_valid   (pix_valid),
	.pix_data    (pix_data),
	.word_valid  (word_valid),
	.first_byte  (first_byte),
	.second_byte (second_byte)
);

endmodule
`default_nettype wire

// *** tb/cam_adv_regs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cam_adv_consts.vh"
module cam_adv_regs_properties (
	input wire logic	clock,
	input wire logic	rstn,
	input wire logic	wb_cyc_i,
	input wire logic	wb_stb_i,
	input wire logic	wb_we_i,
	input wire logic [15:0]	wb_adr_i,
	input wire logic [3:0]	wb_sel_i,
	input wire logic [31:0]	wb_dat_i,
	input wire logic [31:0]	wb_dat_o,
	input wire logic	wb_ack_o,
	input wire logic	trigger_mode_zero,
	input wire logic	trigger_pulse,
	input wire logic	balance_force_on,
	input wire logic [31:0]	tile_gains,
	input wire logic	luma_layout,
	input wire logic	pix_valid,
	input wire logic [9:0]	pix_data,
	input wire logic	word_valid,
	input wire logic [7:0]	first_byte,
	input wire logic [7:0]	second_byte
);
	// ----------------------------------------------------------
	// Helpers and properties
	// ----------------------------------------------------------
	// The core leaves reset two edges after rstn, so checks wait three.
	logic [1:0]	up_reg;
	wire	live = up_reg == 2'h3;
	wire	wr_ack = wb_ack_o && wb_we_i;
	wire [15:0]	pix_exp = luma_layout ? {pix_data[1:0], 6'h0, pix_data[9:2]}
		: {pix_data, 6'h0};
	always @(posedge clock or negedge rstn) begin
		if (!rstn)
			up_reg <= 2'h0;
		else if (!live)
			up_reg <= up_reg + 2'h1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence bus_request;
		live && wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence trig_commit;
		wr_ack && wb_adr_i == `OFS_SOFT_TRIG && wb_sel_i[0] && !wb_dat_i[0];
	endsequence
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	ack_timing_a: assert property (bus_request |=> wb_ack_o)
		else $error("ack did not follow a request");
	idle_data_a: assert property (live && !wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	trig_fire_a: assert property (
		trig_commit |=> trigger_pulse == $past(trigger_mode_zero))
		else $error("trigger pulse wrong after trigger write");
	trig_cause_a: assert property (
		live && trigger_pulse |-> $past(wr_ack))
		else $error("trigger pulse without a write");
	bal_force_a: assert property (
		wr_ack && wb_adr_i == `OFS_TILE_GAINS |=> balance_force_on)
		else $error("gain write did not force balance on");
	bal_cause_a: assert property (
		live && balance_force_on |-> $past(wr_ack && wb_adr_i == `OFS_TILE_GAINS))
		else $error("balance forced without a gain write");
	gain_range_a: assert property ((tile_gains & 32'hc0c0c0c0) == 32'h0)
		else $error("gain above range");
	pack_word_a: assert property (
		live && pix_valid |=> word_valid && {first_byte, second_byte} == $past(pix_exp))
		else $error("packed pixel bytes wrong");
endmodule
bind cam_adv_regs cam_adv_regs_properties i_props (.clock, .rstn, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .trigger_mode_zero,
	.trigger_pulse, .balance_force_on, .tile_gains, .luma_layout, .pix_valid, .pix_data,
	.word_valid, .first_byte, .second_byte);
`default_nettype wire

// *** tb/cam_adv_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cam_adv_consts.vh"
module cam_adv_regs_tb_top;
	// ----------------------------------------------------------
	// Stimulus, monitor and verdict
	// ----------------------------------------------------------
	logic	clock = 1'b0, rstn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic	trigger_mode_zero = 1'b0, integrating = 1'b0, transferring = 1'b0;
	logic	ae_auto = 1'b0, pix_valid = 1'b0;
	logic [15:0]	wb_adr_i = 16'h0, ae_request = 16'h0;
	logic [3:0]	wb_sel_i = 4'h0;
	logic [31:0]	wb_dat_i = 32'h0, r;
	logic [9:0]	pix_data = 10'h0;
	logic	wb_ack_o, trigger_pulse, balance_force_on, luma_layout, word_valid;
	logic [31:0]	wb_dat_o, tile_gains, rd_q[$], px_q[$];
	logic [15:0]	ae_value;
	logic [7:0]	first_byte, second_byte;
	integer	seed = 65, mismatches = 0, n_checks = 0, cycles = 0, i;
	cam_adv_regs i_cam_adv_regs (.clock, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .trigger_mode_zero, .integrating,
		.transferring, .trigger_pulse, .balance_force_on, .tile_gains, .luma_layout, .ae_auto,
		.ae_request, .ae_value, .pix_valid, .pix_data, .word_valid, .first_byte, .second_byte);
	always #12.5 clock = ~clock;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// The master never assumes a latency; only the cycle ceiling ends a wait.
	task automatic wb(input logic w, input logic [15:0] a, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge clock);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		wb(1'b0, a, 4'hf, 32'h0);
	endtask
	always @(posedge clock) begin
		cycles++;
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			check("read data", wb_dat_o, rd_q.pop_front());
		if (word_valid === 1'b1)
			check("packed pixel", {16'h0, first_byte, second_byte}, px_q.pop_front());
		if (cycles == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		repeat (3) @(posedge clock);
		check("gains at reset", tile_gains, 32'h20202020);
		rd(`OFS_TILE_MAP, 32'h52474742);
		wb(1'b1, `OFS_TILE_MAP, 4'hf, $random(seed));
		rd(`OFS_TILE_MAP, 32'h52474742);
		rd(`OFS_TILE_GAINS, 32'h20202020);
		rd(`OFS_LUMA_LAYOUT, 32'h80000000);
		rd(`OFS_AE_BOUNDS, 32'h8000ffff);
		rd(16'h1050, 32'h0);
		for (i = 0; i < 3; i++) begin
			integrating <= i == 0;
			transferring <= i < 2;
			trigger_mode_zero <= i != 1;
			rd(`OFS_SOFT_TRIG, {30'h20000000, i == 0 ? 2'h2 : i == 1 ? 2'h0 : 2'h1});
			wb(1'b1, `OFS_SOFT_TRIG, 4'h1, {31'h0, i == 2});
		end
		wb(1'b1, `OFS_TILE_GAINS, 4'hf, 32'h3f004115);
		wb(1'b1, `OFS_TILE_GAINS, 4'h2, 32'hffff01ff);
		rd(`OFS_TILE_GAINS, 32'h3f000115);
		check("gains port", tile_gains, 32'h3f000115);
		for (i = 0; i < 2; i++) begin
			wb(1'b1, `OFS_LUMA_LAYOUT, 4'hf, {31'h7fffffff, i[0]});
			rd(`OFS_LUMA_LAYOUT, {31'h40000000, i[0]});
			repeat (8) begin
				@(posedge clock);
				r = $random(seed);
				pix_valid <= 1'b1;
				pix_data <= r[9:0];
				px_q.push_back(i ? {16'h0, r[1:0], 6'h0, r[9:2]} : {16'h0, r[9:0], 6'h0});
			end
			@(posedge clock);
			pix_valid <= 1'b0;
		end
		wb(1'b1, `OFS_AE_BOUNDS, 4'hf, 32'hff100200);
		rd(`OFS_AE_BOUNDS, 32'h80100200);
		repeat (40) begin
			@(posedge clock);
			r = $random(seed);
			ae_auto <= r[15];
			ae_request <= {6'h0, r[9:0]};
			@(posedge clock);
			@(negedge clock);
			check("exposure", {16'h0, ae_value}, !r[15] ? {22'h0, r[9:0]} :
				r[9:0] < 10'h10 ? 32'h10 : r[9:0] > 10'h200 ? 32'h200 : {22'h0, r[9:0]});
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
